//--- hw/capture_slot.v
/*
 * One-entry holding slot for a bus channel item (address or write data).
 * Assumes a synchronous active-high reset and that take is only raised
 * while the slot is full.
 */
module capture_slot #(
    parameter W = 14
) (
    input  wire         clk,
    input  wire         reset,
    input  wire         in_valid,
    input  wire [W-1:0] in_data,
    input  wire         take,
    output wire         in_ready,
    output wire         full,
    output wire [W-1:0] data
);

    reg         full_q;
    reg         full_d;
    reg         ready_q;
    reg [W-1:0] data_q;
    wire        accept;

    assign accept   = in_valid & ready_q;
    assign in_ready = ready_q;
    assign full     = full_q;
    assign data     = data_q;

    always @* begin
        full_d = full_q;
        if (accept) begin
            full_d = 1'b1;
        end else if (take) begin
            full_d = 1'b0;
        end
    end

    // Ready is registered so the top sees it straight from a flop
    always @(posedge clk) begin
        if (reset) begin
            full_q  <= 1'b0;
            ready_q <= 1'b1;
            data_q  <= {W{1'b0}};
        end else begin
            full_q  <= full_d;
            ready_q <= ~full_d;
            if (accept) begin
                data_q <= in_data;
            end
        end
    end

endmodule

//--- hw/port_vc_arb_map.vh
/*
 * Register indices, byte addresses, field positions and reset values of the
 * port virtual channel arbitration words.
 * Assumes a 32-bit register bus where each register index takes one word.
 */
`ifndef PORT_VC_ARB_MAP_VH
`define PORT_VC_ARB_MAP_VH

// ---------------------------------------------------------------------------
// Register indices (as printed) and byte addresses (index times four)
// ---------------------------------------------------------------------------
`define VCR_IDX_CAP_ONE        12'h204
`define VCR_IDX_CAP_TWO        12'h208
`define VCR_IDX_CONTROL        12'h20c
`define VCR_IDX_STATUS         12'h20e
`define VCR_IDX_SINK_CTRL      12'h220
`define VCR_IDX_SINK_STAT      12'h221
`define VCR_BYTE(i)            ({(i), 2'b00})

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define LP_COUNT_LSB           4
`define LP_COUNT_MSB           6
`define ARB_CAP_LSB            0
`define ARB_CAP_MSB            7
`define ARB_CAP_USED_MSB       3
`define TBL_OFF_LSB            24
`define TBL_OFF_MSB            31
`define TBL_UNIT_SHIFT         4
`define LOAD_TBL_BIT           0
`define ARB_SEL_LSB            1
`define ARB_SEL_MSB            3
`define TBL_STATUS_BIT         0
`define SINK_CNT_EN_BIT        0
`define SINK_CNT_CLR_BIT       1

// ---------------------------------------------------------------------------
// Reset and fixed values
// ---------------------------------------------------------------------------
`define RST_CAP_ONE            32'h0000_0000
`define RST_CAP_TWO            32'h0000_0000
`define RST_CONTROL            32'h0000_0000
`define RST_STATUS             32'h0000_0000
`define LP_COUNT_VALUE         3'h0
`define ARB_CAP_VALUE          8'h00
`define ARB_CAP_USED_MASK      8'h0f
`define TBL_OFF_VALUE          8'h00
`define LOAD_TBL_VALUE         1'b0
`define ARB_SEL_VALUE          3'h0
`define TBL_STATUS_VALUE       1'b0
`define RST_SINK_CTRL          2'h0
`define RST_SINK_CNT           16'h0000

// ---------------------------------------------------------------------------
// Bus answers
// ---------------------------------------------------------------------------
`define RESP_OKAY              2'h0
`define RESP_DECERR            2'h3

`endif

//--- hw/port_vc_arbitration_regs.v
/*
 * Port virtual channel arbitration words behind an AXI4-Lite slave: second
 * capability word, control word, status word, the low-priority count of the
 * first capability word, and a small sink word pair counting ignored writes.
 * Assumes one clock, a synchronous active-high reset, one write and one read
 * under way at a time, and an AXI4-Lite master keeping the channel rules.
 */
`include "port_vc_arb_map.vh"

// How it works
// - Capability field bit0 fixed round robin, bits1-3 weighted round robin 32/64/128.
// - Capability bits 4 to 7 are reserved and never report a scheme.
// - Capability field is read-only and always reads zero.
// - Table offset in bits 31:24 reads zero, meaning no table present.
// - Table offset is scaled by sixteen bytes from the capability base.
// - Table-load bit at position 0 always reads back zero.
// - Table-load bit never updates any arbitration logic.
// - Scheme select field bits 3:1 reads zero and has no effect.
// - Table status bit 0 of status word always reads zero.
// - Low-priority extra channel count, bits 6:4, reads zero.
module port_vc_arbitration_regs #(
    parameter ADDR_W = 14,
    parameter CNT_W  = 16
) (
    input  wire              SYS_CLK,
    input  wire              RESET,
    input  wire [ADDR_W-1:0] AWADDR,
    input  wire              AWVALID,
    output wire              AWREADY,
    input  wire [31:0]       WDATA,
    input  wire [3:0]        WSTRB,
    input  wire              WVALID,
    output wire              WREADY,
    output reg  [1:0]        BRESP,
    output reg               BVALID,
    input  wire              BREADY,
    input  wire [ADDR_W-1:0] ARADDR,
    input  wire              ARVALID,
    output reg               ARREADY,
    output reg  [31:0]       RDATA,
    output reg  [1:0]        RRESP,
    output reg               RVALID,
    input  wire              RREADY
);

    // -----------------------------------------------------------------------
    // Address constants
    // -----------------------------------------------------------------------
    localparam [ADDR_W-1:0] A_CAP_ONE   = `VCR_BYTE(`VCR_IDX_CAP_ONE);
    localparam [ADDR_W-1:0] A_CAP_TWO   = `VCR_BYTE(`VCR_IDX_CAP_TWO);
    localparam [ADDR_W-1:0] A_CONTROL   = `VCR_BYTE(`VCR_IDX_CONTROL);
    localparam [ADDR_W-1:0] A_STATUS    = `VCR_BYTE(`VCR_IDX_STATUS);
    localparam [ADDR_W-1:0] A_SINK_CTRL = `VCR_BYTE(`VCR_IDX_SINK_CTRL);
    localparam [ADDR_W-1:0] A_SINK_STAT = `VCR_BYTE(`VCR_IDX_SINK_STAT);
    localparam [CNT_W-1:0]  CNT_MAX     = {CNT_W{1'b1}};
    localparam [1:0]        SINK_CTRL_RST = `RST_SINK_CTRL;

    // -----------------------------------------------------------------------
    // Fixed field values of the virtual channel words
    // -----------------------------------------------------------------------
    // Only the default channel exists, so every field is a constant; no
    // flop stands behind them and no write can reach them.
    wire [2:0]  low_priority_extra_channel_count;
    wire [7:0]  vc_arbitration_capability;
    wire [7:0]  arbitration_table_offset;
    wire        load_arbitration_table;
    wire [2:0]  arbitration_scheme_select;
    wire        arbitration_table_status;
    wire [11:0] table_byte_location;

    assign low_priority_extra_channel_count = `LP_COUNT_VALUE;
    // Reserved bits 7:4 are masked so no scheme can appear there
    assign vc_arbitration_capability = `ARB_CAP_VALUE & `ARB_CAP_USED_MASK;
    assign arbitration_table_offset  = `TBL_OFF_VALUE;
    assign load_arbitration_table    = `LOAD_TBL_VALUE;
    assign arbitration_scheme_select = `ARB_SEL_VALUE;
    assign arbitration_table_status  = `TBL_STATUS_VALUE;
    // Offset expressed in bytes: sixteen-byte units from the structure base
    assign table_byte_location = {arbitration_table_offset, {`TBL_UNIT_SHIFT{1'b0}}};

    // -----------------------------------------------------------------------
    // Word assembly
    // -----------------------------------------------------------------------
    reg [31:0] cap_one_word;
    reg [31:0] cap_two_word;
    reg [31:0] control_word;
    reg [31:0] status_word;

    always @* begin
        cap_one_word = `RST_CAP_ONE;
        cap_one_word[`LP_COUNT_MSB:`LP_COUNT_LSB] = low_priority_extra_channel_count;
        cap_two_word = `RST_CAP_TWO;
        cap_two_word[`ARB_CAP_MSB:`ARB_CAP_LSB] = vc_arbitration_capability;
        cap_two_word[`TBL_OFF_MSB:`TBL_OFF_LSB] = arbitration_table_offset;
        control_word = `RST_CONTROL;
        control_word[`LOAD_TBL_BIT] = load_arbitration_table;
        control_word[`ARB_SEL_MSB:`ARB_SEL_LSB] = arbitration_scheme_select;
        status_word = `RST_STATUS;
        status_word[`TBL_STATUS_BIT] = arbitration_table_status;
    end

    // -----------------------------------------------------------------------
    // Write channel capture
    // -----------------------------------------------------------------------
    wire              aw_full;
    wire [ADDR_W-1:0] aw_addr;
    wire              w_full;
    wire [35:0]       w_item;
    wire              wr_fire;

    // Address and data are taken in either order; the response waits on both
    assign wr_fire = aw_full & w_full & ~BVALID;

    capture_slot #(
        .W        (ADDR_W)
    ) aw_slot (
        .clk      (SYS_CLK),
        .reset    (RESET),
        .in_valid (AWVALID),
        .in_data  (AWADDR),
        .take     (wr_fire),
        .in_ready (AWREADY),
        .full     (aw_full),
        .data     (aw_addr)
    );

    capture_slot #(
        .W        (36)
    ) w_slot (
        .clk      (SYS_CLK),
        .reset    (RESET),
        .in_valid (WVALID),
        .in_data  ({WSTRB, WDATA}),
        .take     (wr_fire),
        .in_ready (WREADY),
        .full     (w_full),
        .data     (w_item)
    );

    // -----------------------------------------------------------------------
    // Write decode
    // -----------------------------------------------------------------------
    wire        wr_to_vc_word;
    wire        wr_to_sink_ctrl;
    wire        wr_to_sink_stat;
    wire        wr_mapped;
    wire [3:0]  wr_strb;
    wire [31:0] wr_data;

    assign wr_strb = w_item[35:32];
    assign wr_data = w_item[31:0];

    assign wr_to_vc_word   = (aw_addr == A_CAP_ONE) | (aw_addr == A_CAP_TWO) |
                             (aw_addr == A_CONTROL) | (aw_addr == A_STATUS);
    assign wr_to_sink_ctrl = (aw_addr == A_SINK_CTRL);
    assign wr_to_sink_stat = (aw_addr == A_SINK_STAT);
    assign wr_mapped       = wr_to_vc_word | wr_to_sink_ctrl | wr_to_sink_stat;

    // -----------------------------------------------------------------------
    // Ignored-write sink
    // -----------------------------------------------------------------------
    // Writes to the channel words land here instead of in any field, so the
    // table-load bit cannot start an arbitration update.
    reg             cnt_en_q;
    reg [CNT_W-1:0] ignored_cnt_q;
    reg [CNT_W-1:0] ignored_cnt_d;
    reg             cnt_en_d;

    always @* begin
        cnt_en_d      = cnt_en_q;
        ignored_cnt_d = ignored_cnt_q;
        if (wr_fire && wr_to_sink_ctrl && wr_strb[0]) begin
            cnt_en_d = wr_data[`SINK_CNT_EN_BIT];
            if (wr_data[`SINK_CNT_CLR_BIT]) begin
                ignored_cnt_d = `RST_SINK_CNT;
            end
        end
        // Saturates rather than wraps so a burst of stray writes stays visible
        if (wr_fire && wr_to_vc_word && cnt_en_q && ignored_cnt_q != CNT_MAX) begin
            ignored_cnt_d = ignored_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge SYS_CLK) begin
        if (RESET) begin
            cnt_en_q      <= SINK_CTRL_RST[`SINK_CNT_EN_BIT];
            ignored_cnt_q <= `RST_SINK_CNT;
        end else begin
            cnt_en_q      <= cnt_en_d;
            ignored_cnt_q <= ignored_cnt_d;
        end
    end

    // -----------------------------------------------------------------------
    // Write response
    // -----------------------------------------------------------------------
    always @(posedge SYS_CLK) begin
        if (RESET) begin
            BVALID <= 1'b0;
            BRESP  <= `RESP_OKAY;
        end else if (wr_fire) begin
            BVALID <= 1'b1;
            // Read-only words answer OKAY; only unmapped addresses fail
            BRESP  <= wr_mapped ? `RESP_OKAY : `RESP_DECERR;
        end else if (BVALID && BREADY) begin
            BVALID <= 1'b0;
            BRESP  <= `RESP_OKAY;
        end
    end

    // -----------------------------------------------------------------------
    // Read decode
    // -----------------------------------------------------------------------
    reg [31:0] rd_word;
    reg [1:0]  rd_resp;
    wire       rd_fire;

    assign rd_fire = ARVALID & ARREADY;

    always @* begin
        rd_word = 32'h0000_0000;
        rd_resp = `RESP_OKAY;
        case (ARADDR)
            A_CAP_ONE: begin
                rd_word = cap_one_word;
            end
            A_CAP_TWO: begin
                rd_word = cap_two_word;
            end
            A_CONTROL: begin
                rd_word = control_word;
            end
            A_STATUS: begin
                rd_word = status_word;
            end
            A_SINK_CTRL: begin
                rd_word[`SINK_CNT_EN_BIT] = cnt_en_q;
            end
            A_SINK_STAT: begin
                rd_word = {4'h0, table_byte_location, ignored_cnt_q};
            end
            default: begin
                rd_resp = `RESP_DECERR;
            end
        endcase
    end

    // -----------------------------------------------------------------------
    // Read response
    // -----------------------------------------------------------------------
    // One read at a time: the address port closes until the data is taken
    always @(posedge SYS_CLK) begin
        if (RESET) begin
            ARREADY <= 1'b1;
            RVALID  <= 1'b0;
            RDATA   <= 32'h0000_0000;
            RRESP   <= `RESP_OKAY;
        end else if (rd_fire) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b1;
            RDATA   <= rd_word;
            RRESP   <= rd_resp;
        end else if (RVALID && RREADY) begin
            ARREADY <= 1'b1;
            RVALID  <= 1'b0;
            RDATA   <= 32'h0000_0000;
            RRESP   <= `RESP_OKAY;
        end
    end

endmodule

//--- testbench/port_vc_arbitration_regs_chk.sv
/*
 * Concurrent checks on the port virtual channel arbitration words.
 * Assumes it is bound to the register block and sees only its ports.
 */
`include "port_vc_arb_map.vh"

module port_vc_arbitration_regs_chk #(
    parameter ADDR_W = 14
) (
    input wire              SYS_CLK,
    input wire              RESET,
    input wire [ADDR_W-1:0] AWADDR,
    input wire              AWVALID,
    input wire              AWREADY,
    input wire [1:0]        BRESP,
    input wire              BVALID,
    input wire              BREADY,
    input wire [ADDR_W-1:0] ARADDR,
    input wire              ARVALID,
    input wire              ARREADY,
    input wire [31:0]       RDATA,
    input wire              RVALID,
    input wire              RREADY
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [ADDR_W-1:0] A_ONE = `VCR_BYTE(`VCR_IDX_CAP_ONE);
    localparam logic [ADDR_W-1:0] A_TWO = `VCR_BYTE(`VCR_IDX_CAP_TWO);
    localparam logic [ADDR_W-1:0] A_CTL = `VCR_BYTE(`VCR_IDX_CONTROL);
    localparam logic [ADDR_W-1:0] A_STS = `VCR_BYTE(`VCR_IDX_STATUS);
    logic [ADDR_W-1:0] rd_addr_q;
    logic [ADDR_W-1:0] wr_addr_q;
    logic              ro_wr;

    // ---------------------------------------------------------------
    // Address capture, so read data can be tied to the word it came from
    // ---------------------------------------------------------------
    always @(posedge SYS_CLK) begin
        if (RESET) begin
            rd_addr_q <= '0;
            wr_addr_q <= '0;
        end else begin
            if (ARVALID && ARREADY) rd_addr_q <= ARADDR;
            if (AWVALID && AWREADY) wr_addr_q <= AWADDR;
        end
    end
    assign ro_wr = (wr_addr_q == A_ONE) || (wr_addr_q == A_TWO) ||
                   (wr_addr_q == A_CTL) || (wr_addr_q == A_STS);

    // ---------------------------------------------------------------
    // Properties
    // ---------------------------------------------------------------
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RESET);

    a_cap_scheme_zero: assert property (RVALID && rd_addr_q == A_TWO |-> RDATA[7:0] == 8'h00)
        else $error("capability field not zero");
    a_cap_reserved_zero: assert property (RVALID && rd_addr_q == A_TWO |-> RDATA[7:4] == 4'h0)
        else $error("reserved scheme bit set");
    a_table_offset_zero: assert property (RVALID && rd_addr_q == A_TWO |-> RDATA[31:24] == 8'h00)
        else $error("table offset not zero");
    a_load_bit_zero: assert property (RVALID && rd_addr_q == A_CTL |-> !RDATA[0])
        else $error("table load bit reads one");
    a_select_zero: assert property (RVALID && rd_addr_q == A_CTL |-> RDATA[3:1] == 3'h0)
        else $error("scheme select not zero");
    a_table_status_zero: assert property (RVALID && rd_addr_q == A_STS |-> !RDATA[0])
        else $error("table status reads one");
    a_lp_count_zero: assert property (RVALID && rd_addr_q == A_ONE |-> RDATA[6:4] == 3'h0)
        else $error("low priority count not zero");
    a_ro_write_okay: assert property (BVALID && ro_wr |-> BRESP == `RESP_OKAY)
        else $error("read-only write not answered okay");
    a_read_answer: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
        else $error("read not answered next cycle");
    a_read_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data dropped before taken");
    a_write_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped before taken");
endmodule

bind port_vc_arbitration_regs port_vc_arbitration_regs_chk #(.ADDR_W(ADDR_W))
    port_vc_arbitration_regs_chk_inst (
    .SYS_CLK(SYS_CLK), .RESET(RESET), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
    .RVALID(RVALID), .RREADY(RREADY));

//--- testbench/port_vc_arbitration_regs_test.sv
/*
 * Self-checking bench for the port virtual channel arbitration words.
 * Assumes the register block answers over AXI4-Lite on a single clock.
 */
`include "port_vc_arb_map.vh"

module port_vc_arbitration_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [13:0] A_ONE  = `VCR_BYTE(`VCR_IDX_CAP_ONE);
    localparam logic [13:0] A_TWO  = `VCR_BYTE(`VCR_IDX_CAP_TWO);
    localparam logic [13:0] A_CTL  = `VCR_BYTE(`VCR_IDX_CONTROL);
    localparam logic [13:0] A_STS  = `VCR_BYTE(`VCR_IDX_STATUS);
    localparam logic [13:0] A_SCTL = `VCR_BYTE(`VCR_IDX_SINK_CTRL);
    localparam logic [13:0] A_SSTS = `VCR_BYTE(`VCR_IDX_SINK_STAT);
    localparam logic [13:0] RO_ADDR [4] = '{A_ONE, A_TWO, A_CTL, A_STS};
    logic        SYS_CLK, RESET, AWVALID, WVALID, BREADY, ARVALID, RREADY;
    logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic [13:0] AWADDR, ARADDR;
    logic [31:0] WDATA, RDATA;
    logic [3:0]  WSTRB;
    logic [1:0]  BRESP, RRESP;
    int          failures = 0;
    int          comparisons = 0;
    int          cycles = 0;

    port_vc_arbitration_regs port_vc_arbitration_regs_inst (
        .SYS_CLK(SYS_CLK), .RESET(RESET), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
        .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
        .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
        .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));

    // ---------------------------------------------------------------
    // Compares and bus cycles
    // ---------------------------------------------------------------
    task automatic check_data(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Both channels offered at once; each released only at its own handshake.
    // A nonzero lag holds the answer ready back, so the slave must keep its answer.
    task automatic axi_write(input logic [13:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] r, input int lag);
        int   n;
        logic got;
        n = 0;
        got = 1'b0;
        r = 2'h1;
        @(posedge SYS_CLK);
        AWADDR <= a;
        AWVALID <= 1'b1;
        WDATA <= d;
        WSTRB <= s;
        WVALID <= 1'b1;
        BREADY <= (lag == 0);
        while (!got && n < 50) begin
            @(posedge SYS_CLK);
            n++;
            if (AWVALID && AWREADY === 1'b1) AWVALID <= 1'b0;
            if (WVALID && WREADY === 1'b1) WVALID <= 1'b0;
            if (BVALID === 1'b1 && BREADY) begin
                got = 1'b1;
                r = BRESP;
                BREADY <= 1'b0;
            end else if (n >= lag) begin
                BREADY <= 1'b1;
            end
        end
        if (!got) failures++;
    endtask
    task automatic axi_read(input logic [13:0] a, output logic [31:0] d, output logic [1:0] r,
                            input int lag);
        int   n;
        logic got;
        n = 0;
        got = 1'b0;
        d = 32'hdead_beef;
        r = 2'h1;
        @(posedge SYS_CLK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= (lag == 0);
        while (!got && n < 50) begin
            @(posedge SYS_CLK);
            n++;
            if (ARVALID && ARREADY === 1'b1) ARVALID <= 1'b0;
            if (RVALID === 1'b1 && RREADY) begin
                got = 1'b1;
                d = RDATA;
                r = RRESP;
                RREADY <= 1'b0;
            end else if (n >= lag) begin
                RREADY <= 1'b1;
            end
        end
        if (!got) failures++;
    endtask
    task automatic rd_check(input string what, input logic [13:0] a, input logic [31:0] ed,
                            input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(a, d, r, 0);
        check_data(what, ed, d);
        check_resp(what, er, r);
    endtask
    task automatic wr_check(input string what, input logic [13:0] a, input logic [31:0] d,
                            input logic [3:0] s, input logic [1:0] er);
        logic [1:0] r;
        axi_write(a, d, s, r, 0);
        check_resp(what, er, r);
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic test_ro_fields();
        logic [31:0] d;
        logic [1:0]  r;
        // Count is read before the capability field is trusted
        axi_read(A_ONE, d, r, 0);
        check_data("low priority count", 32'h0, 32'(d[6:4]));
        axi_read(A_TWO, d, r, 0);
        check_data("arbitration capability", 32'h0, 32'(d[7:0]));
        check_data("capability reserved", 32'h0, 32'(d[7:4]));
        check_data("table offset", 32'h0, 32'(d[31:24]));
        check_resp("capability answer", `RESP_OKAY, r);
        axi_read(A_CTL, d, r, 0);
        check_data("load table bit", 32'h0, 32'(d[0]));
        check_data("scheme select", 32'h0, 32'(d[3:1]));
        rd_check("table status", A_STS, 32'h0, `RESP_OKAY);
    endtask
    task automatic test_ro_writes();
        // Sink counter proves the writes arrived although nothing changed
        wr_check("sink enable", A_SCTL, 32'h1, 4'h1, `RESP_OKAY);
        for (int i = 0; i < 4; i++) wr_check("ro write", RO_ADDR[i], 32'hffff_ffff, 4'hf, `RESP_OKAY);
        for (int i = 0; i < 4; i++) rd_check("ro after write", RO_ADDR[i], 32'h0, `RESP_OKAY);
        rd_check("sink count", A_SSTS, 32'h0000_0004, `RESP_OKAY);
        wr_check("sink clear", A_SCTL, 32'h2, 4'h1, `RESP_OKAY);
        wr_check("load table", A_CTL, 32'h1, 4'hf, `RESP_OKAY);
        rd_check("sink cleared", A_SSTS, 32'h0, `RESP_OKAY);
        rd_check("control after load", A_CTL, 32'h0, `RESP_OKAY);
        rd_check("status after load", A_STS, 32'h0, `RESP_OKAY);
    endtask
    task automatic test_unmapped();
        // Printed offset used as a byte address must miss the map
        rd_check("byte misread", 14'h020c, 32'h0, `RESP_DECERR);
        rd_check("unmapped read", 14'h0ffc, 32'h0, `RESP_DECERR);
        wr_check("unmapped write", 14'h0ffc, 32'hffff_ffff, 4'hf, `RESP_DECERR);
        rd_check("sink control", A_SCTL, 32'h0, `RESP_OKAY);
    endtask
    task automatic test_slow_ready();
        logic [31:0] d;
        logic [1:0]  r;
        // Answers must stand while the master is slow to take them
        wr_check("sink enable again", A_SCTL, 32'h1, 4'h1, `RESP_OKAY);
        axi_read(A_SCTL, d, r, 3);
        check_data("slow sink control", 32'h1, d);
        check_resp("slow read answer", `RESP_OKAY, r);
        axi_write(14'h0ffc, 32'h1, 4'hf, r, 3);
        check_resp("slow unmapped write", `RESP_DECERR, r);
        axi_write(A_STS, 32'h1, 4'hf, r, 3);
        check_resp("slow ro write", `RESP_OKAY, r);
        rd_check("slow sink count", A_SSTS, 32'h0000_0001, `RESP_OKAY);
        rd_check("status after slow write", A_STS, 32'h0, `RESP_OKAY);
    endtask

    // ---------------------------------------------------------------
    // Clock, reset, sequence and verdict
    // ---------------------------------------------------------------
    task automatic summarize();
        if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        SYS_CLK = 1'b0;
        forever #4 SYS_CLK = ~SYS_CLK;
    end
    always @(posedge SYS_CLK) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            summarize();
        end
    end
    initial begin
        {RESET, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 6'h20;
        {AWADDR, ARADDR, WDATA, WSTRB} = '0;
        repeat (8) @(posedge SYS_CLK);
        RESET <= 1'b0;
        test_ro_fields();
        test_ro_writes();
        test_unmapped();
        test_slow_ready();
        summarize();
    end
endmodule
